// ---- pkg/adcsq_pkg.sv ----
// shared constants and types for the converter sequence control
package adcsq_pkg;
    // wishbone register byte addresses
    localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] ADDR_OPTIONS = 8'h04;
    localparam logic [7:0] ADDR_SLOT_ONE = 8'h08;
    localparam logic [7:0] ADDR_SLOT_TWO = 8'h0C;
    localparam logic [7:0] ADDR_SLOT_THREE = 8'h10;
    localparam logic [7:0] ADDR_SLOT_FOUR = 8'h14;
    // control/status field positions
    localparam int DONE_BIT = 7;
    localparam int SCAN_BIT = 5;
    localparam int MULTI_BIT = 4;
    localparam int CHAN_MSB = 3;
    // options field position, options and control reset values
    localparam int CLOCK_SELECT_BIT = 6;
    localparam logic [7:0] OPTIONS_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // conversion timing in converter clock ticks, and number of result slots
    localparam int CONV_TICKS = 32;
    localparam int SAMPLE_TICKS = CONV_TICKS - 8;
    localparam int SLOTS = 4;
    // input selection codes
    localparam logic [3:0] CODE_REF_HIGH = 4'hC;
    localparam logic [3:0] CODE_REF_LOW = 4'hD;
    localparam logic [3:0] CODE_REF_HALF = 4'hE;
    // mux source routed to the analog comparator
    typedef enum logic [3:0] {
        SRC_INPUT_0, SRC_INPUT_1, SRC_INPUT_2, SRC_INPUT_3,
        SRC_INPUT_4, SRC_INPUT_5, SRC_INPUT_6, SRC_INPUT_7,
        SRC_REF_HIGH, SRC_REF_LOW, SRC_REF_HALF, SRC_NONE
    } adcsq_source_type;
    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE, ST_START, ST_SAMPLE, ST_COMPARE
    } adcsq_state_type;
endpackage

// ---- core/adcsq_tick_gen.sv ----
// converter tick generator: system clock divider or resynchronised rc oscillator
module adcsq_tick_gen #(
    parameter int DIVIDE = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // selection and sources
    input wire logic use_rc_clock,
    input wire logic rc_osc,
    // tick out
    output logic tick
);
    logic [7:0] div_reg, div_next;
    logic sync1_reg, sync2_reg, sync3_reg;
    logic tick_reg, tick_next;

    // divider count and tick decision
    always_comb begin
        div_next = div_reg;
        tick_next = 1'b0;
        if (use_rc_clock) begin
            div_next = 8'h00;
            tick_next = sync2_reg & ~sync3_reg;
        end else if (div_reg == 8'(DIVIDE - 1)) begin
            div_next = 8'h00;
            tick_next = 1'b1;
        end else begin
            div_next = div_reg + 8'h01;
        end
    end

    // registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            div_reg <= 8'h00;
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            sync1_reg <= rc_osc;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;
endmodule

// ---- core/adcsq_mux_decode.sv ----
// channel select decode into the analog mux source for one conversion
module adcsq_mux_decode (
    // selection
    input wire logic [3:0] channel_select_bits,
    input wire logic multi_channel_select,
    input wire logic [1:0] slot_index,
    // decoded source
    output adcsq_pkg::adcsq_source_type source
);
    logic [3:0] code;

    // multi-channel replaces the low two bits with the slot number
    always_comb begin
        code = multi_channel_select ? {channel_select_bits[3:2], slot_index} : channel_select_bits;
        if (!code[3]) begin
            source = adcsq_pkg::adcsq_source_type'({1'b0, code[2:0]});
        end else if (code == adcsq_pkg::CODE_REF_HIGH) begin
            source = adcsq_pkg::SRC_REF_HIGH;
        end else if (code == adcsq_pkg::CODE_REF_LOW) begin
            source = adcsq_pkg::SRC_REF_LOW;
        end else if (code == adcsq_pkg::CODE_REF_HALF) begin
            source = adcsq_pkg::SRC_REF_HALF;
        end else begin
            source = adcsq_pkg::SRC_NONE; // reserved codes route nothing
        end
    end
endmodule

// ---- core/adcsq_control.sv ----
// sequence control of an eight-input successive-approximation converter with wishbone registers
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
module adcsq_control #(
    parameter int TICK_DIVIDE = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // analog front end
    input wire logic rc_osc,
    input wire logic comparator_out,
    output adcsq_pkg::adcsq_source_type mux_source,
    output logic sample_enable,
    output logic [7:0] dac_code
);
    adcsq_pkg::adcsq_state_type state_reg, state_next;
    logic [7:0] control_reg, control_next;
    logic [7:0] options_reg, options_next;
    logic [7:0] sar_reg, sar_next;
    logic [7:0] slot_reg [adcsq_pkg::SLOTS];
    logic [7:0] slot_next [adcsq_pkg::SLOTS];
    logic [1:0] slot_idx_reg, slot_idx_next;
    logic [2:0] bit_idx_reg, bit_idx_next;
    logic [4:0] tick_cnt_reg, tick_cnt_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;
    logic tick;
    logic bus_req, ctl_write, opt_write, low_lane;
    adcsq_pkg::adcsq_source_type decoded_source;

    // converter clock source
    adcsq_tick_gen #(
        .DIVIDE(TICK_DIVIDE)
    ) u_tick (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .use_rc_clock(options_reg[adcsq_pkg::CLOCK_SELECT_BIT]),
        .rc_osc(rc_osc),
        .tick(tick)
    );

    // input selection for the slot being converted
    adcsq_mux_decode u_decode (
        .channel_select_bits(control_reg[adcsq_pkg::CHAN_MSB:0]),
        .multi_channel_select(control_reg[adcsq_pkg::MULTI_BIT]),
        .slot_index(slot_idx_reg),
        .source(decoded_source)
    );

    // bus request qualification
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign low_lane = wb_sel_i[0];
    assign ctl_write = bus_req & wb_we_i & low_lane & (wb_adr_i == adcsq_pkg::ADDR_CONTROL_STATUS);
    assign opt_write = bus_req & wb_we_i & low_lane & (wb_adr_i == adcsq_pkg::ADDR_OPTIONS);

    // read decode; unmapped addresses read zero
    always_comb begin
        rdata_next = rdata_reg;
        ack_next = bus_req;
        if (bus_req && !wb_we_i) begin
            if (wb_adr_i == adcsq_pkg::ADDR_CONTROL_STATUS) begin
                rdata_next = {24'h000000, control_reg & 8'hBF}; // bit 6 reads zero
            end else if (wb_adr_i == adcsq_pkg::ADDR_OPTIONS) begin
                rdata_next = {24'h000000, options_reg};
            end else if (wb_adr_i == adcsq_pkg::ADDR_SLOT_ONE) begin
                rdata_next = {24'h000000, slot_reg[0]};
            end else if (wb_adr_i == adcsq_pkg::ADDR_SLOT_TWO) begin
                rdata_next = {24'h000000, slot_reg[1]};
            end else if (wb_adr_i == adcsq_pkg::ADDR_SLOT_THREE) begin
                rdata_next = {24'h000000, slot_reg[2]};
            end else if (wb_adr_i == adcsq_pkg::ADDR_SLOT_FOUR) begin
                rdata_next = {24'h000000, slot_reg[3]};
            end else begin
                rdata_next = 32'h00000000;
            end
        end
    end

    // sequencer and register next state
    always_comb begin
        state_next = state_reg;
        control_next = control_reg;
        options_next = options_reg;
        sar_next = sar_reg;
        slot_next = slot_reg;
        slot_idx_next = slot_idx_reg;
        bit_idx_next = bit_idx_reg;
        tick_cnt_next = tick_cnt_reg;
        if (opt_write) begin
            options_next = wb_dat_i[7:0] & 8'h40;
        end
        if (ctl_write) begin
            // done flag is read-only and cleared by the write
            control_next = {1'b0, 1'b0, wb_dat_i[5:0]};
            state_next = adcsq_pkg::ST_START;
            slot_idx_next = 2'b00;
        end else begin
            case (state_reg)
                adcsq_pkg::ST_IDLE: begin
                end
                adcsq_pkg::ST_START: begin
                    // two cycles after the write, sampling begins
                    state_next = adcsq_pkg::ST_SAMPLE;
                    tick_cnt_next = 5'd0;
                    sar_next = 8'h80;
                    bit_idx_next = 3'd7;
                end
                adcsq_pkg::ST_SAMPLE: begin
                    if (tick) begin
                        if (tick_cnt_reg == 5'(adcsq_pkg::SAMPLE_TICKS - 1)) begin
                            state_next = adcsq_pkg::ST_COMPARE;
                        end
                        tick_cnt_next = tick_cnt_reg + 5'd1;
                    end
                end
                adcsq_pkg::ST_COMPARE: begin
                    if (tick) begin
                        tick_cnt_next = tick_cnt_reg + 5'd1;
                        // keep the trial bit when input is at or above it, then try the next one
                        sar_next[bit_idx_reg] = comparator_out;
                        if (bit_idx_reg != 3'd0) begin
                            sar_next[bit_idx_reg - 3'd1] = 1'b1;
                            bit_idx_next = bit_idx_reg - 3'd1;
                        end else begin
                            // slot write lands on a clock edge; read data is registered, so a read never tears
                            slot_next[slot_idx_reg] = {sar_reg[7:1], comparator_out};
                            slot_idx_next = slot_idx_reg + 2'd1;
                            if (slot_idx_reg == 2'd3) begin
                                control_next[adcsq_pkg::DONE_BIT] = 1'b1;
                            end
                            if (slot_idx_reg == 2'd3 && !control_reg[adcsq_pkg::SCAN_BIT]) begin
                                state_next = adcsq_pkg::ST_IDLE;
                            end else begin
                                state_next = adcsq_pkg::ST_START;
                            end
                        end
                    end
                end
                default: state_next = adcsq_pkg::ST_IDLE;
            endcase
        end
    end

    // registers update
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_reg <= adcsq_pkg::ST_IDLE;
            control_reg <= adcsq_pkg::CONTROL_RESET;
            options_reg <= adcsq_pkg::OPTIONS_RESET;
            sar_reg <= 8'h00;
            slot_idx_reg <= 2'b00;
            bit_idx_reg <= 3'd7;
            tick_cnt_reg <= 5'd0;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            for (int i = 0; i < adcsq_pkg::SLOTS; i++) begin
                slot_reg[i] <= 8'h00;
            end
        end else begin
            state_reg <= state_next;
            control_reg <= control_next;
            options_reg <= options_next;
            sar_reg <= sar_next;
            slot_idx_reg <= slot_idx_next;
            bit_idx_reg <= bit_idx_next;
            tick_cnt_reg <= tick_cnt_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next; // read data is captured in its own cycle, so a slot write never tears it
            slot_reg <= slot_next;
        end
    end

    // outputs
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign mux_source = decoded_source;
    assign sample_enable = (state_reg == adcsq_pkg::ST_SAMPLE);
    assign dac_code = sar_reg;
endmodule

// ---- testbench/adcsq_sva.sv ----
// checker for the converter sequence control ports
module adcsq_sva #(
    parameter int TICK_DIVIDE = 4
) (
    // clock, reset and bus
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // converter side
    input wire adcsq_pkg::adcsq_source_type mux_source,
    input wire logic sample_enable,
    input wire logic [7:0] dac_code
);
    localparam int SLO = adcsq_pkg::SAMPLE_TICKS * TICK_DIVIDE;
    logic wr, wo, rc_reg, rc_next;
    logic [7:0] cnt_reg, cnt_next;
    // accepted writes to control and options
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == 8'h00;
    assign wo = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == 8'h04;
    // clock select copy and sampling length count
    always_comb begin
        rc_next = wo ? wb_dat_i[6] : rc_reg;
        cnt_next = sample_enable ? cnt_reg + 8'h01 : 8'h00;
    end
    always_ff @(posedge ref_clk) begin
        rc_reg <= reset_n ? rc_next : 1'b0;
        cnt_reg <= reset_n ? cnt_next : 8'h00;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    rd_hold_a: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i) |=> $stable(wb_dat_o)) else $error("rd moved");
    upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper bits");
    start_delay_a: assert property (wr && !rc_reg |-> ##2 sample_enable) else $error("start late");
    dac_trial_a: assert property (sample_enable |-> dac_code == 8'h80) else $error("trial not msb");
    sample_len_a: assert property ($fell(sample_enable) && !rc_reg && !$past(wr) |->
        cnt_reg >= SLO && cnt_reg <= SLO + TICK_DIVIDE) else $error("sample length");
    mux_hold_a: assert property (sample_enable && $past(sample_enable) |-> $stable(mux_source)) else $error("mux");
    cover property (wr);
    cover property ($fell(sample_enable));
    cover property (wb_ack_o && !wb_we_i);
endmodule
bind adcsq_control adcsq_sva #(.TICK_DIVIDE(TICK_DIVIDE)) adcsq_sva_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mux_source(mux_source),
    .sample_enable(sample_enable), .dac_code(dac_code));

// ---- testbench/adcsq_analog_model.sv ----
// analog front end model: input levels, references, rc oscillator
module adcsq_analog_model (
    // clock and levels
    input wire logic ref_clk,
    input wire logic [63:0] levels,
    // converter side
    input wire adcsq_pkg::adcsq_source_type mux_source,
    input wire logic [7:0] dac_code,
    output logic comparator_out,
    output logic rc_osc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] s;
    logic [7:0] lvl;
    logic [2:0] rc_cnt = 3'h0;
    assign s = mux_source;
    // level of the routed source; high and low references sit at the rails, the half reference at 7F
    always_comb begin
        case (s)
            4'h8: lvl = 8'hFF;
            4'h9: lvl = 8'h00;
            4'hA: lvl = 8'h7F;
            default: lvl = levels[{s[2:0], 3'b000} +: 8];
        endcase
    end
    // comparator high while input is at or above the trial
    assign comparator_out = lvl >= dac_code;
    // slow free-running oscillator
    always @(posedge ref_clk) rc_cnt <= rc_cnt + 3'h1;
    assign rc_osc = rc_cnt[2];
endmodule

// ---- testbench/test_adc_sequence_control.sv ----
// self-checking bench for the converter sequence control
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module test_adc_sequence_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CS = adcsq_pkg::ADDR_CONTROL_STATUS;
    localparam logic [7:0] OPT = adcsq_pkg::ADDR_OPTIONS;
    localparam logic [7:0] S1 = adcsq_pkg::ADDR_SLOT_ONE;
    logic ref_clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, chk = 1'b0;
    logic [7:0] adr = 8'h00, dac, old;
    logic [31:0] wdat = 32'h0, rdat, r, e, lfsr = 32'h7052b8d8;
    logic [3:0] sel = 4'hF, sl = 4'hF;
    logic [63:0] lv = 64'h0;
    logic ack, rco, cmp, se;
    adcsq_pkg::adcsq_source_type src;
    logic [31:0] expq[$];
    int n_mismatch = 0, checks = 0;
    logic [7:0] codes [7] = '{8'h00, 8'h07, 8'h0C, 8'h0D, 8'h0E, 8'h13, 8'h16};
    adcsq_control #(.TICK_DIVIDE(1)) adcsq_control_inst (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
        .wb_ack_o(ack), .rc_osc(rco), .comparator_out(cmp), .mux_source(src), .sample_enable(se), .dac_code(dac));
    adcsq_analog_model adcsq_analog_model_inst (.ref_clk(ref_clk), .levels(lv), .mux_source(src),
        .dac_code(dac), .comparator_out(cmp), .rc_osc(rco));
    // clock source
    initial forever #2.5 ref_clk = ~ref_clk;
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // expected code of a source selection
    function automatic logic [31:0] lvl_of(input logic [3:0] c);
        case (c)
            4'hC: return 32'hFF;
            4'hD: return 32'h00;
            4'hE: return 32'hFF >> 1;
            default: return {24'h0, lv[{c[2:0], 3'b000} +: 8]};
        endcase
    endfunction
    // fresh random input levels
    task automatic rnd();
        logic [63:0] t;
        repeat (64) begin
            lfsr = nxt(lfsr);
            t = {t[62:0], lfsr[0]};
        end
        lv <= t;
    endtask
    // one classic wishbone cycle; checked reads note the expected value
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= sl;
        chk <= c;
        if (c)
            expq.push_back(d);
        @(posedge ref_clk);
        while (ack !== 1'b1) @(posedge ref_clk);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk <= 1'b0;
        @(posedge ref_clk);
    endtask
    // start a sequence, wait for the done flag, check the four slots
    task automatic run(input logic [7:0] code);
        bus(1'b1, CS, {24'h0, code}, 1'b0);
        bus(1'b0, CS, {24'h0, code}, 1'b1);
        r = 32'h0;
        while (r[7] !== 1'b1) bus(1'b0, CS, 32'h0, 1'b0);
        bus(1'b0, CS, {24'h0, code | 8'h80}, 1'b1);
        for (int s = 0; s < 4; s++)
            bus(1'b0, S1 + 8'(4 * s), lvl_of(code[4] ? {code[3:2], 2'(s)} : code[3:0]), 1'b1);
        $display("test code %h done", code);
    endtask
    // compare each checked read with the oldest note
    always @(posedge ref_clk) begin
        if (ack === 1'b1 && chk === 1'b1 && we === 1'b0) begin
            e = expq.pop_front();
            `CHK(rdat, e)
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #100000;
        n_mismatch++;
        finish_test();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        bus(1'b0, CS, 32'h0, 1'b1);
        bus(1'b0, OPT, 32'h0, 1'b1);
        bus(1'b0, 8'h20, 32'h0, 1'b1);
        bus(1'b1, S1, 32'hFF, 1'b0);
        bus(1'b0, S1, 32'h0, 1'b1);
        $display("test reset done");
        foreach (codes[i]) begin
            rnd();
            run(codes[i]);
        end
        old = lv[39:32];
        rnd();
        repeat (300) @(posedge ref_clk);
        bus(1'b0, S1, {24'h0, old}, 1'b1);
        bus(1'b1, CS, 32'h25, 1'b0);
        r = 32'h0;
        while (r[7] !== 1'b1) bus(1'b0, CS, 32'h0, 1'b0);
        rnd();
        repeat (300) @(posedge ref_clk);
        bus(1'b0, CS, 32'hA5, 1'b1);
        for (int s = 0; s < 4; s++)
            bus(1'b0, S1 + 8'(4 * s), lvl_of(4'h5), 1'b1);
        $display("test scan done");
        bus(1'b1, CS, 32'h01, 1'b0);
        repeat (40) @(posedge ref_clk);
        run(8'h02);
        bus(1'b1, OPT, 32'h40, 1'b0);
        bus(1'b0, OPT, 32'h40, 1'b1);
        run(8'h06);
        bus(1'b1, OPT, 32'h0, 1'b0);
        sl = 4'hE;
        bus(1'b1, CS, 32'h01, 1'b0);
        sl = 4'hF;
        bus(1'b0, CS, 32'h86, 1'b1);
        $display("test options done");
        finish_test();
    end
endmodule
